/* File: hw/tgtr_pkg.sv */
package tgtr_pkg;

  // ==========================================================
  // Register offsets (byte addresses, one aligned word each)
  // ==========================================================
  localparam logic [7:0] OFS_WP_SELECT  = 8'h00;
  localparam logic [7:0] OFS_POWER_STAT = 8'h04;
  localparam logic [7:0] OFS_MISC_IN    = 8'h08;
  localparam logic [7:0] OFS_TRIG_TEST  = 8'h0c;
  localparam logic [7:0] OFS_READY_TEST = 8'h10;
  localparam logic [7:0] OFS_VALID_TEST = 8'h14;
  localparam logic [7:0] OFS_INTEG_CTRL = 8'h18;
  localparam logic [7:0] OFS_GATE_STAT  = 8'h1c;

  // ==========================================================
  // Field layout
  // ==========================================================
  localparam int unsigned WP_NUM        = 4;
  localparam int unsigned SEL_START_LSB = 0;
  localparam int unsigned SEL_STOP_LSB  = 16;
  localparam int unsigned MISC_HALT_BIT = 4;
  localparam int unsigned MISC_EXT_LSB  = 0;
  localparam int unsigned EXT_NUM       = 2;
  localparam int unsigned TEST_BIT      = 0;

  // ==========================================================
  // Reset and fixed values
  // ==========================================================
  localparam logic [3:0]  RST_SEL       = 4'h0;
  localparam logic        RST_BIT       = 1'b0;
  localparam logic [31:0] POWER_STAT_VAL = 32'h0000_0001;

endpackage : tgtr_pkg

/* File: hw/tgtr_gate.sv */
module tgtr_gate (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [3:0] wp_in,
  input  wire logic [3:0] start_sel,
  input  wire logic [3:0] stop_sel,
  output logic            gate_q
);

  // ==========================================================
  // Start and stop resources
  // ==========================================================
  logic [3:0] start_hit;
  logic [3:0] stop_hit;
  logic       any_start;
  logic       any_stop;

  genvar g;
  generate
    for (g = 0; g < tgtr_pkg::WP_NUM; g++) begin : g_wp
      assign start_hit[g] = wp_in[g] & start_sel[g];
      assign stop_hit[g]  = wp_in[g] & stop_sel[g];
    end
  endgenerate

  assign any_start = |start_hit;
  assign any_stop  = |stop_hit;

  // Stop wins over a simultaneous start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_q <= tgtr_pkg::RST_BIT;
    end else if (ce) begin
      if (any_stop) begin
        gate_q <= 1'b0;
      end else if (any_start) begin
        gate_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_stop_clears_gate: assert property (
    @(posedge clk) disable iff (rst)
    (ce && |(wp_in & stop_sel)) |=> !gate_q)
    else $error("Selected stop input did not close the gate");

  a_start_opens_gate: assert property (
    @(posedge clk) disable iff (rst)
    (ce && |(wp_in & start_sel) && !(|(wp_in & stop_sel))) |=> gate_q)
    else $error("Selected start input did not open the gate");

  a_unselected_ignored: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !(|(wp_in & start_sel)) && !gate_q) |=> !gate_q)
    else $error("Gate opened without a selected start input");

endmodule : tgtr_gate

/* File: hw/tgtr_regs.sv */
// Overview of operation
// - Bits 19 to 16 of the select register each enable watchpoint inputs 1 to 4 as a gate stop.
// - Bits 3 to 0 of the select register each enable watchpoint inputs 1 to 4 as a gate start.
// - The power status register always reads 1 in bit 0 and zero in bits 31 to 1.
// - The misc input test register reads the live halt pin in bit 4 and external inputs in 1:0.
// - In integration mode, writing bit 0 of the trigger test register drives that value on the trigger output.
// - Bit 0 of the ready test register reads the live trace bus ready input.
// - In integration mode, writing bit 0 of the valid test register sets the level on the trace bus valid output.
module tgtr_regs (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [3:0]  WATCHPOINT_IN,
  input  wire logic        CORE_HALTED_INPUT,
  input  wire logic [1:0]  EXTERNAL_INPUT,
  input  wire logic        TRACE_BUS_READY_IN,
  input  wire logic        FUNC_TRIGGER,
  input  wire logic        FUNC_BUS_VALID,
  output logic             TRACE_TRIGGER_OUTPUT,
  output logic             TRACE_BUS_VALID_OUT,
  output logic             TRACE_GATE
);

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic        ack_q;
  logic [31:0] dat_q;
  logic        req;
  logic        wr;
  logic        rd;
  logic        hit_sel;
  logic        hit_pwr;
  logic        hit_misc;
  logic        hit_trig;
  logic        hit_rdy;
  logic        hit_vld;
  logic        hit_ctl;
  logic        hit_gate;

  function automatic logic adr_is(input logic [7:0] a, input logic [7:0] ofs);
    adr_is = (a[7:2] == ofs[7:2]);
  endfunction : adr_is

  assign req      = CE && WB_CYC_I && WB_STB_I && !ack_q;
  assign wr       = req && WB_WE_I;
  assign rd       = req && !WB_WE_I;
  assign hit_sel  = adr_is(WB_ADR_I, tgtr_pkg::OFS_WP_SELECT);
  assign hit_pwr  = adr_is(WB_ADR_I, tgtr_pkg::OFS_POWER_STAT);
  assign hit_misc = adr_is(WB_ADR_I, tgtr_pkg::OFS_MISC_IN);
  assign hit_trig = adr_is(WB_ADR_I, tgtr_pkg::OFS_TRIG_TEST);
  assign hit_rdy  = adr_is(WB_ADR_I, tgtr_pkg::OFS_READY_TEST);
  assign hit_vld  = adr_is(WB_ADR_I, tgtr_pkg::OFS_VALID_TEST);
  assign hit_ctl  = adr_is(WB_ADR_I, tgtr_pkg::OFS_INTEG_CTRL);
  assign hit_gate = adr_is(WB_ADR_I, tgtr_pkg::OFS_GATE_STAT);

  // ==========================================================
  // Control registers
  // ==========================================================
  logic [3:0] start_sel_q;
  logic [3:0] stop_sel_q;
  logic       itmode_q;
  logic       trig_val_q;
  logic       valid_val_q;
  logic       gate;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      start_sel_q <= tgtr_pkg::RST_SEL;
      stop_sel_q  <= tgtr_pkg::RST_SEL;
    end else if (wr && hit_sel) begin
      if (WB_SEL_I[0]) begin
        start_sel_q <= WB_DAT_I[tgtr_pkg::SEL_START_LSB +: 4];
      end
      if (WB_SEL_I[2]) begin
        stop_sel_q <= WB_DAT_I[tgtr_pkg::SEL_STOP_LSB +: 4];
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      itmode_q <= tgtr_pkg::RST_BIT;
    end else if (wr && hit_ctl && WB_SEL_I[0]) begin
      itmode_q <= WB_DAT_I[tgtr_pkg::TEST_BIT];
    end
  end

  // Test values only take writes in integration mode
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      trig_val_q <= tgtr_pkg::RST_BIT;
    end else if (CE) begin
      if (!itmode_q) begin
        trig_val_q <= 1'b0;
      end else if (wr && hit_trig && WB_SEL_I[0]) begin
        trig_val_q <= WB_DAT_I[tgtr_pkg::TEST_BIT];
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      valid_val_q <= tgtr_pkg::RST_BIT;
    end else if (CE) begin
      if (!itmode_q) begin
        valid_val_q <= 1'b0;
      end else if (wr && hit_vld && WB_SEL_I[0]) begin
        valid_val_q <= WB_DAT_I[tgtr_pkg::TEST_BIT];
      end
    end
  end

  // ==========================================================
  // Driven outputs
  // ==========================================================
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      TRACE_TRIGGER_OUTPUT <= tgtr_pkg::RST_BIT;
      TRACE_BUS_VALID_OUT  <= tgtr_pkg::RST_BIT;
    end else if (CE) begin
      TRACE_TRIGGER_OUTPUT <= itmode_q ? trig_val_q : FUNC_TRIGGER;
      TRACE_BUS_VALID_OUT  <= itmode_q ? valid_val_q : FUNC_BUS_VALID;
    end
  end

  tgtr_gate u_gate (
    .clk       (CLK_SYS),
    .rst       (RST),
    .ce        (CE),
    .wp_in     (WATCHPOINT_IN),
    .start_sel (start_sel_q),
    .stop_sel  (stop_sel_q),
    .gate_q    (gate)
  );

  assign TRACE_GATE = gate;

  // ==========================================================
  // Read data and acknowledge
  // ==========================================================
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_sel) begin
      rdata[tgtr_pkg::SEL_START_LSB +: 4] = start_sel_q;
      rdata[tgtr_pkg::SEL_STOP_LSB +: 4]  = stop_sel_q;
    end else if (hit_pwr) begin
      rdata = tgtr_pkg::POWER_STAT_VAL;
    end else if (hit_misc) begin
      rdata[tgtr_pkg::MISC_HALT_BIT] = CORE_HALTED_INPUT;
      rdata[tgtr_pkg::MISC_EXT_LSB +: tgtr_pkg::EXT_NUM] = EXTERNAL_INPUT;
    end else if (hit_rdy) begin
      rdata[tgtr_pkg::TEST_BIT] = TRACE_BUS_READY_IN;
    end else if (hit_ctl) begin
      rdata[tgtr_pkg::TEST_BIT] = itmode_q;
    end else if (hit_gate) begin
      rdata[tgtr_pkg::TEST_BIT] = gate;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else if (CE) begin
      ack_q <= req;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dat_q <= 32'h0000_0000;
    end else if (CE) begin
      dat_q <= rd ? rdata : 32'h0000_0000;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // ==========================================================
  // Assertions
  // ==========================================================
  a_power_reads_one: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (rd && hit_pwr) |=> (WB_ACK_O && WB_DAT_O == 32'h0000_0001))
    else $error("Power status did not read as one");

  a_misc_live_pins: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (rd && hit_misc) |=> (WB_ACK_O && WB_DAT_O[4] == $past(CORE_HALTED_INPUT)
      && WB_DAT_O[1:0] == $past(EXTERNAL_INPUT) && WB_DAT_O[31:5] == 27'h0))
    else $error("Misc input read did not show the pins");

  a_trig_write_out: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (wr && hit_trig && WB_SEL_I[0] && itmode_q) ##1 (CE && itmode_q)
      |=> (TRACE_TRIGGER_OUTPUT == $past(WB_DAT_I[0], 2)))
    else $error("Trigger output did not follow the test write");

  a_ready_live_read: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (rd && hit_rdy) |=> (WB_DAT_O == {31'h0, $past(TRACE_BUS_READY_IN)}))
    else $error("Ready test read did not show the input");

  a_valid_write_out: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (wr && hit_vld && WB_SEL_I[0] && itmode_q) ##1 (CE && itmode_q)
      |=> (TRACE_BUS_VALID_OUT == $past(WB_DAT_I[0], 2)))
    else $error("Valid output did not follow the test write");

  a_trig_value_holds: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (itmode_q && !(wr && hit_trig)) |=> $stable(trig_val_q))
    else $error("Trigger test value changed without a write");

  a_valid_value_holds: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (itmode_q && !(wr && hit_vld)) |=> $stable(valid_val_q))
    else $error("Valid test value changed without a write");

  a_exit_clears_test: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && !itmode_q) |=> (!trig_val_q && !valid_val_q))
    else $error("Test values not cleared outside integration mode");

  a_select_written: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (wr && hit_sel && WB_SEL_I[2]) |=> (stop_sel_q == $past(WB_DAT_I[19:16])))
    else $error("Stop selection not written");

  a_start_written: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (wr && hit_sel && WB_SEL_I[0]) |=> (start_sel_q == $past(WB_DAT_I[3:0])))
    else $error("Start selection not written");

  a_select_readback: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (rd && hit_sel) |=> (WB_DAT_O == {12'h000, $past(stop_sel_q), 12'h000, $past(start_sel_q)}))
    else $error("Select read did not show both fields");

  a_trig_out_follows: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && itmode_q) |=> (TRACE_TRIGGER_OUTPUT == $past(trig_val_q)))
    else $error("Trigger output did not show the test value");

  a_valid_out_follows: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && itmode_q) |=> (TRACE_BUS_VALID_OUT == $past(valid_val_q)))
    else $error("Valid output did not show the test value");

  a_func_trig_pass: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && !itmode_q) |=> (TRACE_TRIGGER_OUTPUT == $past(FUNC_TRIGGER)))
    else $error("Functional trigger not passed through");

  a_func_valid_pass: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && !itmode_q) |=> (TRACE_BUS_VALID_OUT == $past(FUNC_BUS_VALID)))
    else $error("Functional valid not passed through");

  a_ce_freezes_state: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    !CE |=> ($stable(TRACE_TRIGGER_OUTPUT) && $stable(TRACE_BUS_VALID_OUT)
      && $stable(WB_ACK_O) && $stable(WB_DAT_O) && $stable(TRACE_GATE) && $stable(itmode_q)))
    else $error("State changed while the clock enable was low");

  a_ack_follows_req: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    req |=> WB_ACK_O)
    else $error("Request was not acknowledged in the next cycle");

  a_read_idle_zero: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    !WB_ACK_O |-> (WB_DAT_O == 32'h0000_0000))
    else $error("Read data not zero outside the acknowledge");

  a_write_reads_zero: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    wr |=> (WB_DAT_O == 32'h0000_0000))
    else $error("Write acknowledge carried read data");

  a_gate_status_read: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (rd && hit_gate) |=> (WB_DAT_O == {31'h0, $past(gate)}))
    else $error("Gate status read did not show the gate");

  a_ack_one_cycle: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && WB_ACK_O) |=> !WB_ACK_O)
    else $error("Acknowledge lasted more than one cycle");

endmodule : tgtr_regs

/* File: sim/tgtr_far_model.sv */
module tgtr_far_model (
  input  wire logic       trig_in,
  input  wire logic [7:0] cti_drive,
  input  wire logic       ready_level,
  output logic      [1:0] ext_out,
  output logic            ready_out,
  output logic      [7:0] cti_seen,
  output logic            irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Cross trigger wiring and trace bus sink
  // ==========================================================
  assign ext_out   = cti_drive[5:4];
  assign cti_seen  = {trig_in, 7'h00};
  assign irq_out   = cti_drive[2];
  assign ready_out = ready_level;
endmodule : tgtr_far_model

/* File: sim/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, ce, cyc, stb, we, halt, ready_lvl, ftrig, fvalid;
  logic [7:0] adr, cti_drive, cti_seen;
  logic [3:0] sel, wp;
  logic [31:0] dat_w, dat_r, rd;
  logic ack, trig, bvalid, gate, ready_in, irq;
  logic [1:0] ext;
  int failures, checks, i;
  tgtr_regs dut (.CLK_SYS(clk), .RST(rst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
    .WB_ACK_O(ack), .WATCHPOINT_IN(wp), .CORE_HALTED_INPUT(halt), .EXTERNAL_INPUT(ext),
    .TRACE_BUS_READY_IN(ready_in), .FUNC_TRIGGER(ftrig), .FUNC_BUS_VALID(fvalid),
    .TRACE_TRIGGER_OUTPUT(trig), .TRACE_BUS_VALID_OUT(bvalid), .TRACE_GATE(gate));
  tgtr_far_model far (.trig_in(trig), .cti_drive(cti_drive), .ready_level(ready_lvl),
    .ext_out(ext), .ready_out(ready_in), .cti_seen(cti_seen), .irq_out(irq));
  // ==========================================================
  // Clock, checks and bus tasks
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop;
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= 4'hf;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      report_and_stop();
    end else begin
      rd = dat_r;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    end
  endtask : wb
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
  endtask : settle
  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    dat_w = 32'h0000_0000; wp = 4'h0; halt = 1'b0; ready_lvl = 1'b0;
    ftrig = 1'b0; fvalid = 1'b0; cti_drive = 8'h00;
    ce = 1'b1;
    failures = 0; checks = 0; rd = 32'h0000_0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, tgtr_pkg::OFS_WP_SELECT, 32'h0000_0000);
    chk("select reset", rd, 32'h0000_0000);
    wb(1'b0, tgtr_pkg::OFS_POWER_STAT, 32'h0000_0000);
    chk("power status", rd, 32'h0000_0001);
    wb(1'b1, tgtr_pkg::OFS_POWER_STAT, 32'h0000_0000);
    wb(1'b0, tgtr_pkg::OFS_POWER_STAT, 32'h0000_0000);
    chk("power status kept", rd, 32'h0000_0001);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    wb(1'b1, tgtr_pkg::OFS_WP_SELECT, 32'hffff_ffff);
    wb(1'b0, tgtr_pkg::OFS_WP_SELECT, 32'h0000_0000);
    chk("select fields", rd, 32'h000f_000f);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, tgtr_pkg::OFS_WP_SELECT, (32'h1 << i) | (32'h1 << (16 + (i + 1) % 4)));
      wp <= 4'h1 << i;
      settle(2);
      chk("gate start", {31'h0, gate}, 32'h1);
      wp <= ~((4'h1 << i) | (4'h1 << ((i + 1) % 4)));
      settle(2);
      chk("gate unselected", {31'h0, gate}, 32'h1);
      wp <= 4'h1 << ((i + 1) % 4);
      settle(2);
      chk("gate stop", {31'h0, gate}, 32'h0);
      wb(1'b0, tgtr_pkg::OFS_GATE_STAT, 32'h0000_0000);
      chk("gate status", rd, 32'h0000_0000);
      wp <= 4'h0;
    end
    for (i = 0; i < 8; i++) begin
      cti_drive <= {2'b00, i[1:0], 1'b0, i[2], 2'b00};
      halt <= i[2];
      ready_lvl <= i[0];
      wb(1'b0, tgtr_pkg::OFS_MISC_IN, 32'h0000_0000);
      chk("misc input", rd, {27'h0, i[2], 2'b00, i[1:0]});
      wb(1'b0, tgtr_pkg::OFS_READY_TEST, 32'h0000_0000);
      chk("ready test", rd, {31'h0, i[0]});
      chk("irq line", {31'h0, irq}, {31'h0, i[2]});
    end
    wb(1'b1, tgtr_pkg::OFS_TRIG_TEST, 32'h0000_0001);
    ftrig <= 1'b1;
    fvalid <= 1'b1;
    settle(2);
    chk("trig functional", {31'h0, trig}, 32'h1);
    chk("valid functional", {31'h0, bvalid}, 32'h1);
    chk("cti trigger in", {24'h0, cti_seen}, 32'h80);
    ce <= 1'b0;
    ftrig <= 1'b0;
    fvalid <= 1'b0;
    settle(2);
    chk("trig frozen", {31'h0, trig}, 32'h1);
    chk("valid frozen", {31'h0, bvalid}, 32'h1);
    ce <= 1'b1;
    settle(2);
    chk("trig released", {31'h0, trig}, 32'h0);
    ftrig <= 1'b0;
    wb(1'b1, tgtr_pkg::OFS_INTEG_CTRL, 32'h0000_0001);
    wb(1'b1, tgtr_pkg::OFS_TRIG_TEST, 32'h0000_0001);
    wb(1'b1, tgtr_pkg::OFS_VALID_TEST, 32'h0000_0001);
    settle(1);
    chk("trig test", {31'h0, trig}, 32'h1);
    chk("valid test", {31'h0, bvalid}, 32'h1);
    fvalid <= 1'b0;
    settle(5);
    chk("trig held", {31'h0, trig}, 32'h1);
    chk("valid held", {31'h0, bvalid}, 32'h1);
    wb(1'b0, tgtr_pkg::OFS_TRIG_TEST, 32'h0000_0000);
    chk("trig test read", rd, 32'h0000_0000);
    wb(1'b1, tgtr_pkg::OFS_TRIG_TEST, 32'h0000_0000);
    settle(1);
    chk("trig cleared", {31'h0, trig}, 32'h0);
    chk("valid kept", {31'h0, bvalid}, 32'h1);
    wb(1'b1, tgtr_pkg::OFS_INTEG_CTRL, 32'h0000_0000);
    settle(1);
    chk("valid mode off", {31'h0, bvalid}, 32'h0);
    rst <= 1'b1;
    settle(2);
    rst <= 1'b0;
    wb(1'b0, tgtr_pkg::OFS_WP_SELECT, 32'h0000_0000);
    chk("select after reset", rd, 32'h0000_0000);
    report_and_stop();
  end
endmodule : testbench
